// ===== adcc_analog_model.sv
// Behavioural sample-and-hold with an ideal comparator for the converter
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
  // Clock
  input  wire logic       clk_i,
  // Converter side
  input  wire logic [5:0] channel_i,
  input  wire logic       sample_i,
  input  wire logic [9:0] dac_code_i,
  output logic            cmp_o
);
  logic [9:0] level [64];
  logic [9:0] held;
  initial begin
    held = 10'h000;
    foreach (level[i]) level[i] = 10'h000;
  end
  // Tracks the routed channel only while acquiring; later input moves are not seen
  always @(posedge clk_i) begin
    if (sample_i) begin
      held <= level[channel_i];
    end
  end
  assign cmp_o = (held >= dac_code_i);
endmodule
`default_nettype wire

// ===== adcc_pkg.sv
// Register map, field positions, reset values and timing constants for the converter control
package adcc_pkg;
  // Register byte offsets, one 32-bit word each
  localparam logic [5:0] CTRL0_OFS   = 6'h00;
  localparam logic [5:0] CHAN_OFS    = 6'h04;
  localparam logic [5:0] REFCFG_OFS  = 6'h08;
  localparam logic [5:0] CLKDIV_OFS  = 6'h0C;
  localparam logic [5:0] RESHI_OFS   = 6'h10;
  localparam logic [5:0] RESLO_OFS   = 6'h14;
  localparam logic [5:0] PREV_OFS    = 6'h18;
  localparam logic [5:0] FLAG_OFS    = 6'h1C;
  localparam logic [5:0] IRQEN_OFS   = 6'h20;
  // converter_control_reg0 fields
  localparam int CTRL_ON_BIT     = 0;
  localparam int CTRL_GO_BIT     = 1;
  localparam int CTRL_CONT_BIT   = 2;
  localparam int CTRL_FMT_BIT    = 3;
  localparam int CTRL_CS_BIT     = 4;
  localparam int CTRL_DS_BIT     = 5;
  // reference_config_reg fields
  localparam int REF_POS_LSB     = 0;
  localparam int REF_NEG_BIT     = 4;
  // Flag and enable fields
  localparam int FLAG_DONE_BIT   = 0;
  localparam int FLAG_THR_BIT    = 1;
  localparam int EN_CONV_BIT     = 0;
  localparam int EN_THR_BIT      = 1;
  localparam int EN_PERIPH_BIT   = 2;
  localparam int EN_GLOBAL_BIT   = 3;
  // Positive reference encodings
  localparam logic [2:0] PREF_PIN   = 3'h0;
  localparam logic [2:0] PREF_VDD   = 3'h1;
  localparam logic [2:0] PREF_F1024 = 3'h2;
  localparam logic [2:0] PREF_F2048 = 3'h3;
  localparam logic [2:0] PREF_F4096 = 3'h4;
  // Reset values
  localparam logic [5:0] CTRL0_RST  = 6'h00;
  localparam logic [5:0] CHAN_RST   = 6'h00;
  localparam logic [5:0] CLKDIV_RST = 6'h00;
  localparam logic [15:0] RES_RST   = 16'h0000;
  // Divider and conversion timing, counted in half bit periods
  localparam logic [5:0] DIV_MAX_CODE    = 6'h3F;
  localparam logic [6:0] DIV_MAX_HALF    = 7'h40;
  localparam logic [4:0] PHASE_SAMPLE_END = 5'h02;
  localparam logic [5:0] PHASE_FIRST_BIT = 6'h04;
  localparam logic [5:0] PHASE_LAST_BIT  = 6'h16;
  localparam logic [5:0] PHASE_DONE      = 6'h17;
  localparam logic [9:0] SAR_MSB_INIT    = 10'h200;
  typedef enum logic [0:0] {ADCC_IDLE, ADCC_CONVERT} adcc_state_t;
endpackage

// ===== adcc_top.sv
// Converter control: registers, clock divider, SAR sequencing, results and wake logic
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Analog front end
  input  wire logic        cmp_i,
  input  wire logic        rc_tick_i,
  input  wire logic        thresh_hit_i,
  output logic      [5:0]  channel_o,
  output logic      [2:0]  pos_ref_o,
  output logic             neg_ref_o,
  output logic             sample_o,
  output logic      [9:0]  dac_code_o,
  output logic             busy_o,
  // Core power and interrupt side
  input  wire logic        sleep_i,
  output logic             wake_o,
  output logic             vector_o,
  output logic             inline_o
);
  function automatic logic [6:0] div_half(input logic [5:0] code);
    div_half = (code == adcc_pkg::DIV_MAX_CODE) ? adcc_pkg::DIV_MAX_HALF : {1'b0, code};
  endfunction

  function automatic logic [9:0] sar_step(input logic [9:0] sar, input logic [3:0] idx,
                                          input logic cmp);
    logic [9:0] r;
    r = sar;
    r[idx] = cmp;
    if (idx != 4'h0) begin
      r[idx - 4'h1] = 1'b1;
    end
    sar_step = r;
  endfunction

  adcc_pkg::adcc_state_t state_reg, state_next;
  logic [5:0]  ctrl_reg;
  logic [5:0]  chan_reg;
  logic [2:0]  pref_reg;
  logic        nref_reg;
  logic [5:0]  div_reg;
  logic [15:0] res_reg;
  logic [15:0] prev_reg;
  logic [1:0]  flag_reg;
  logic [3:0]  en_reg;
  logic [6:0]  dcnt_reg, dcnt_next;
  logic [4:0]  phase_reg;
  logic [9:0]  sar_reg;
  logic        second_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        sample_reg;
  logic        wake_reg;
  logic        vector_reg;
  logic        inline_reg;

  // Bus decode
  wire        bus_req  = wb_cyc_i && wb_stb_i && !ack_reg;
  wire        bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  wire        wr_ctrl  = bus_wr && (wb_adr_i == adcc_pkg::CTRL0_OFS);
  wire        wr_chan  = bus_wr && (wb_adr_i == adcc_pkg::CHAN_OFS);
  wire        wr_ref   = bus_wr && (wb_adr_i == adcc_pkg::REFCFG_OFS);
  wire        wr_div   = bus_wr && (wb_adr_i == adcc_pkg::CLKDIV_OFS);
  wire        wr_hi    = bus_wr && (wb_adr_i == adcc_pkg::RESHI_OFS);
  wire        wr_lo    = bus_wr && (wb_adr_i == adcc_pkg::RESLO_OFS);
  wire        wr_flag  = bus_wr && (wb_adr_i == adcc_pkg::FLAG_OFS);
  wire        wr_en    = bus_wr && (wb_adr_i == adcc_pkg::IRQEN_OFS);

  wire        adc_on   = ctrl_reg[adcc_pkg::CTRL_ON_BIT];
  wire        go_bit   = ctrl_reg[adcc_pkg::CTRL_GO_BIT];
  wire        cont_bit = ctrl_reg[adcc_pkg::CTRL_CONT_BIT];
  wire        fmt_bit  = ctrl_reg[adcc_pkg::CTRL_FMT_BIT];
  wire        rc_src   = ctrl_reg[adcc_pkg::CTRL_CS_BIT];
  wire        ds_bit   = ctrl_reg[adcc_pkg::CTRL_DS_BIT];

  // Result read view; format bit low means left justified
  wire [7:0]  rd_hi    = fmt_bit ? res_reg[15:8]
                                 : (res_reg[9:2] | {res_reg[15:14], 6'h00});
  wire [7:0]  rd_lo    = fmt_bit ? res_reg[7:0] : {res_reg[1:0], 6'h00};
  wire [31:0] rd_data  =
    (wb_adr_i == adcc_pkg::CTRL0_OFS)  ? {26'h0000000, ctrl_reg} :
    (wb_adr_i == adcc_pkg::CHAN_OFS)   ? {26'h0000000, chan_reg} :
    (wb_adr_i == adcc_pkg::REFCFG_OFS) ? {27'h0000000, nref_reg, 1'b0, pref_reg} :
    (wb_adr_i == adcc_pkg::CLKDIV_OFS) ? {26'h0000000, div_reg} :
    (wb_adr_i == adcc_pkg::RESHI_OFS)  ? {24'h000000, rd_hi} :
    (wb_adr_i == adcc_pkg::RESLO_OFS)  ? {24'h000000, rd_lo} :
    (wb_adr_i == adcc_pkg::PREV_OFS)   ? {16'h0000, prev_reg} :
    (wb_adr_i == adcc_pkg::FLAG_OFS)   ? {30'h00000000, flag_reg} :
    (wb_adr_i == adcc_pkg::IRQEN_OFS)  ? {28'h0000000, en_reg} : 32'h00000000;

  // Conversion clock: half bit period steps from divider, RC tick or system clock
  wire [6:0]  half_n   = div_half(div_reg);
  wire        fosc_sel = !rc_src && (div_reg == 6'h00);
  wire        div_half_tick = (dcnt_reg == half_n - 7'h01);
  wire        div_tad_tick  = (dcnt_reg == {half_n[5:0], 1'b0} - 7'h01);
  wire        sleep_hold = sleep_i && !rc_src;
  wire [1:0]  step =
    (!adc_on || sleep_hold) ? 2'h0 :
    rc_src                  ? {1'b0, rc_tick_i} :
    fosc_sel                ? 2'h2 :
                              {1'b0, div_half_tick || div_tad_tick};

  always_comb begin
    dcnt_next = dcnt_reg + 7'h01;
    // A new divider restarts the bit period, so no stale count carries over
    if (!adc_on || rc_src || fosc_sel || div_tad_tick || wr_div) begin
      dcnt_next = 7'h00;
    end
  end

  // Sequencing
  wire [5:0]  phase_sum  = {1'b0, phase_reg} + {4'h0, step};
  wire        bit_slot   = (step != 2'h0) && !phase_sum[0] &&
                           (phase_sum >= adcc_pkg::PHASE_FIRST_BIT) &&
                           (phase_sum <= adcc_pkg::PHASE_LAST_BIT);
  wire [5:0]  slot_off   = phase_sum - adcc_pkg::PHASE_FIRST_BIT;
  wire [3:0]  bit_idx    = 4'h9 - slot_off[4:1];
  wire        converting = (state_reg == adcc_pkg::ADCC_CONVERT);
  wire        start      = !converting && adc_on && go_bit && (step != 2'h0);
  wire        abort      = converting && !go_bit;
  wire        done_evt   = converting && go_bit && (step != 2'h0) &&
                           (phase_sum >= adcc_pkg::PHASE_DONE);
  wire        restart    = done_evt && ((ds_bit && !second_reg) || cont_bit);
  wire        go_hw_clr  = done_evt && !restart;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcc_pkg::ADCC_IDLE: begin
        if (start) begin
          state_next = adcc_pkg::ADCC_CONVERT;
        end
      end
      adcc_pkg::ADCC_CONVERT: begin
        if (abort || go_hw_clr) begin
          state_next = adcc_pkg::ADCC_IDLE;
        end
      end
      default: begin
        state_next = adcc_pkg::ADCC_IDLE;
      end
    endcase
  end

  // Interrupt and wake requests from sticky flags
  wire        pend   = (flag_reg[adcc_pkg::FLAG_DONE_BIT] && en_reg[adcc_pkg::EN_CONV_BIT]) ||
                       (flag_reg[adcc_pkg::FLAG_THR_BIT] && en_reg[adcc_pkg::EN_THR_BIT]);
  wire        vec_en = en_reg[adcc_pkg::EN_PERIPH_BIT] && en_reg[adcc_pkg::EN_GLOBAL_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= adcc_pkg::ADCC_IDLE;
      phase_reg  <= 5'h00;
      sar_reg    <= 10'h000;
      second_reg <= 1'b0;
      dcnt_reg   <= 7'h00;
    end else begin
      state_reg <= state_next;
      dcnt_reg  <= dcnt_next;
      if (start || restart) begin
        phase_reg  <= 5'h00;
        sar_reg    <= adcc_pkg::SAR_MSB_INIT;
        second_reg <= restart && ds_bit && !second_reg;
      end else if (converting && (step != 2'h0)) begin
        phase_reg <= phase_sum[4:0];
        if (bit_slot) begin
          sar_reg <= sar_step(sar_reg, bit_idx, cmp_i);
        end
      end
      if (abort) begin
        second_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= adcc_pkg::CTRL0_RST;
      chan_reg <= adcc_pkg::CHAN_RST;
      pref_reg <= adcc_pkg::PREF_PIN;
      nref_reg <= 1'b0;
      div_reg  <= adcc_pkg::CLKDIV_RST;
      en_reg   <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wb_dat_i[5:0];
      end else if (go_hw_clr) begin
        ctrl_reg[adcc_pkg::CTRL_GO_BIT] <= 1'b0;
      end
      if (wr_chan) begin
        chan_reg <= wb_dat_i[5:0];
      end
      if (wr_ref) begin
        pref_reg <= (wb_dat_i[2:0] > adcc_pkg::PREF_F4096) ? adcc_pkg::PREF_PIN
                                                           : wb_dat_i[2:0];
        nref_reg <= wb_dat_i[adcc_pkg::REF_NEG_BIT];
      end
      if (wr_div) begin
        div_reg <= wb_dat_i[5:0];
      end
      if (wr_en) begin
        en_reg <= wb_dat_i[3:0];
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_reg  <= adcc_pkg::RES_RST;
      prev_reg <= adcc_pkg::RES_RST;
      flag_reg <= 2'h0;
    end else begin
      if (done_evt) begin
        res_reg  <= {6'h00, sar_reg};
        prev_reg <= res_reg;
      end else begin
        if (wr_hi) begin
          res_reg[15:8] <= wb_dat_i[7:0];
        end
        if (wr_lo) begin
          res_reg[7:0] <= wb_dat_i[7:0];
        end
      end
      if (wr_flag) begin
        flag_reg <= wb_dat_i[1:0];
      end
      if (done_evt) begin
        flag_reg[adcc_pkg::FLAG_DONE_BIT] <= 1'b1;
      end
      if (thresh_hit_i) begin
        flag_reg[adcc_pkg::FLAG_THR_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg    <= 1'b0;
      dat_reg    <= 32'h00000000;
      sample_reg <= 1'b0;
      wake_reg   <= 1'b0;
      vector_reg <= 1'b0;
      inline_reg <= 1'b0;
    end else begin
      ack_reg    <= bus_req;
      dat_reg    <= bus_req ? rd_data : 32'h00000000;
      sample_reg <= (state_next == adcc_pkg::ADCC_CONVERT) &&
                    ((start || restart) ? 1'b1 : (phase_sum[4:0] < adcc_pkg::PHASE_SAMPLE_END));
      wake_reg   <= sleep_i && pend;
      vector_reg <= pend && vec_en;
      inline_reg <= pend && !en_reg[adcc_pkg::EN_GLOBAL_BIT];
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = dat_reg;
  assign channel_o  = chan_reg;
  assign pos_ref_o  = pref_reg;
  assign neg_ref_o  = nref_reg;
  assign sample_o   = sample_reg;
  assign dac_code_o = sar_reg;
  assign busy_o     = (state_reg == adcc_pkg::ADCC_CONVERT);
  assign wake_o     = wake_reg;
  assign vector_o   = vector_reg;
  assign inline_o   = inline_reg;

  // Checks
  logic [7:0] tad_gap_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || div_tad_tick || wr_div || !adc_on || rc_src || fosc_sel) begin
      tad_gap_reg <= 8'h01;
    end else if (tad_gap_reg != 8'hFF) begin
      tad_gap_reg <= tad_gap_reg + 8'h01;
    end
  end

  chk_flag_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
    done_evt |=> flag_reg[adcc_pkg::FLAG_DONE_BIT])
    else $error("done flag not set after completion");
  chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    flag_reg[adcc_pkg::FLAG_DONE_BIT] && !wr_flag |=> flag_reg[adcc_pkg::FLAG_DONE_BIT])
    else $error("done flag dropped without software write");
  chk_go_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    done_evt && !cont_bit && !(ds_bit && !second_reg) && !wr_ctrl |=> !go_bit && !busy_o)
    else $error("go bit not cleared at completion");
  chk_cont_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    done_evt && cont_bit && !wr_ctrl |=> go_bit && busy_o && (dac_code_o == 10'h200))
    else $error("continuous mode did not restart");
  chk_result_prev: assert property (@(posedge clk_i) disable iff (rst_i)
    done_evt |=> (res_reg == {6'h00, $past(sar_reg)}) && (prev_reg == $past(res_reg)))
    else $error("result pair or previous result wrong");
  chk_left_view: assert property (@(posedge clk_i) disable iff (rst_i)
    !fmt_bit |-> (rd_lo[5:0] == 6'h00) && (rd_hi[5:0] == res_reg[7:2]))
    else $error("left justified view not shifted by six");
  chk_tad_period: assert property (@(posedge clk_i) disable iff (rst_i)
    div_tad_tick && !fosc_sel && !rc_src && adc_on && !$past(wr_div) && (tad_gap_reg != 8'hFF)
    && $past(adc_on) |-> tad_gap_reg == {half_n, 1'b0})
    else $error("bit period not 2n system clocks");
  chk_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i && !rc_src && busy_o && go_bit && !wr_ctrl |=> $stable(phase_reg) && $stable(sar_reg))
    else $error("conversion progressed in sleep without RC clock");
  chk_fosc_length: assert property (@(posedge clk_i) disable iff (rst_i)
    start && fosc_sel && !sleep_i |=> (busy_o && go_bit && !wr_ctrl && !sleep_i)[*8]
    ##1 (busy_o && go_bit && !wr_ctrl && !sleep_i)[*3] ##1 done_evt)
    else $error("system clock conversion length wrong");
  chk_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    pend && vec_en |=> vector_o && !inline_o)
    else $error("vector request missing");
  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle after request");

  cov_done: cover property (@(posedge clk_i) disable iff (rst_i) done_evt);
  cov_double: cover property (@(posedge clk_i) disable iff (rst_i) done_evt && ds_bit && second_reg);
  cov_cont: cover property (@(posedge clk_i) disable iff (rst_i) restart && cont_bit);
  cov_abort: cover property (@(posedge clk_i) disable iff (rst_i) abort);
  cov_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
endmodule
`default_nettype wire

// ===== adcc_top_test.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_top_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [5:0]  wb_adr_i = 6'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic        rc_tick_i = 1'b0;
  logic        thresh_hit_i = 1'b0;
  logic        sleep_i = 1'b0;
  logic        rc_run = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        cmp_i;
  logic [5:0]  channel_o;
  logic [2:0]  pos_ref_o;
  logic        neg_ref_o;
  logic        sample_o;
  logic [9:0]  dac_code_o;
  logic        busy_o;
  logic        wake_o;
  logic        vector_o;
  logic        inline_o;
  logic [31:0] rd;
  logic [9:0]  lv;
  logic [15:0] prev;
  logic [5:0]  ch;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          res_q[$];
  int          codes[4] = '{0, 1, 0, 63};
  int          len, tk, h, e;

  adcc_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_i, .rc_tick_i, .thresh_hit_i, .channel_o,
    .pos_ref_o, .neg_ref_o, .sample_o, .dac_code_o, .busy_o, .sleep_i, .wake_o,
    .vector_o, .inline_o);
  adcc_analog_model i_ana (.clk_i, .channel_i(channel_o), .sample_i(sample_o),
    .dac_code_i(dac_code_o), .cmp_o(cmp_i));

  always #5 clk_i = ~clk_i;
  // Irregular oscillator steps, so no fixed ratio to the system clock is assumed
  always @(posedge clk_i) rc_tick_i <= rc_run && ($urandom_range(2, 0) == 0);

  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fail();
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask

  task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d);
    int n;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h000000, d};
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) fail();
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    check(rd, {24'h000000, exp});
  endtask

  task automatic wait_idle();
    int n;
    begin
      n = 0;
      while (busy_o !== 1'b0 && n < 4000) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 4000) fail();
    end
  endtask

  task automatic run_conv(input logic [7:0] ctrl);
    int n;
    begin
      wb(1'b1, 6'h00, ctrl);
      len = 0;
      tk = 0;
      n = 0;
      while (busy_o !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      while (busy_o === 1'b1 && n < 4000) begin
        @(posedge clk_i);
        n++;
        len++;
        tk += int'(rc_tick_i);
      end
      if (n >= 4000 || len == 0) fail();
    end
  endtask

  task automatic pick(input logic [9:0] v);
    ch = 6'($urandom_range(63, 0));
    i_ana.level[ch] = v;
    wb(1'b1, 6'h04, {2'h0, ch});
    check({26'h0, channel_o}, {26'h0, ch});
    repeat (10) @(posedge clk_i);
    lv = v;
  endtask

  initial begin
    void'($urandom(32'h735D75AF));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 64; a += 4) rdchk(6'(a), 8'h00);
    wb(1'b1, 6'h3C, 8'hFF);
    rdchk(6'h3C, 8'h00);
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, 6'h08, {3'h0, 1'(p), 1'b0, 3'(p)});
      check({29'h0, pos_ref_o}, (p > 4) ? 0 : p);
      check({31'h0, neg_ref_o}, p % 2);
    end
    wb(1'b1, 6'h00, 8'h09);
    prev = 16'h0000;
    codes[2] = $urandom_range(62, 2);
    foreach (codes[i]) begin
      pick(10'($urandom));
      res_q.push_back(lv);
      wb(1'b1, 6'h0C, 8'(codes[i]));
      run_conv(8'h0B);
      h = (codes[i] == 63) ? 64 : ((codes[i] == 0) ? 1 : codes[i]);
      e = (codes[i] == 0) ? 12 : 23 * h;
      check(32'(len >= e - 1 && len <= e + h + 1), 32'h1);
      rdchk(6'h10, 8'(res_q[$] >> 8));
      rdchk(6'h14, 8'(res_q[$]));
      wb(1'b0, 6'h18, 8'h00);
      check({24'h0, rd[7:0]}, {24'h0, prev[7:0]});
      prev = 16'(res_q[$]);
      rdchk(6'h00, 8'h09);
      rdchk(6'h1C, 8'h01);
      wb(1'b1, 6'h1C, 8'h00);
    end
    wb(1'b1, 6'h00, 8'h01);
    rdchk(6'h10, lv[9:2]);
    rdchk(6'h14, {lv[1:0], 6'h00});
    wb(1'b1, 6'h10, 8'h80);
    wb(1'b1, 6'h14, 8'hFF);
    rdchk(6'h10, 8'hBF);
    rdchk(6'h14, 8'hC0);
    wb(1'b1, 6'h00, 8'h09);
    rdchk(6'h10, 8'h80);
    rdchk(6'h14, 8'hFF);
    wb(1'b1, 6'h0C, 8'h00);
    wb(1'b1, 6'h00, 8'h0F);
    repeat (60) @(posedge clk_i);
    rdchk(6'h00, 8'h0F);
    wb(1'b1, 6'h00, 8'h09);
    wait_idle();
    pick(~lv);
    run_conv(8'h2B);
    wb(1'b0, 6'h18, 8'h00);
    check({24'h0, rd[7:0]}, {24'h0, lv[7:0]});
    rdchk(6'h14, lv[7:0]);
    wb(1'b1, 6'h0C, 8'h01);
    sleep_i <= 1'b1;
    wb(1'b1, 6'h00, 8'h0B);
    repeat (30) @(posedge clk_i);
    check({31'h0, busy_o}, 32'h0);
    rdchk(6'h00, 8'h0B);
    sleep_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check({31'h0, sample_o}, 32'h1);
    repeat (4) @(posedge clk_i);
    // Asleep mid-conversion on a divided clock: progress must freeze
    sleep_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    check({30'h0, busy_o, sample_o}, 32'h2);
    sleep_i <= 1'b0;
    wait_idle();
    wb(1'b1, 6'h1C, 8'h00);
    wb(1'b1, 6'h20, 8'h01);
    sleep_i <= 1'b1;
    rc_run <= 1'b1;
    run_conv(8'h1B);
    check(32'(tk >= 22 && tk <= 25), 32'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, wake_o}, 32'h1);
    sleep_i <= 1'b0;
    rc_run <= 1'b0;
    repeat (50) @(posedge clk_i);
    rdchk(6'h1C, 8'h01);
    wb(1'b1, 6'h20, 8'h0D);
    repeat (2) @(posedge clk_i);
    check({30'h0, vector_o, inline_o}, 32'h2);
    wb(1'b1, 6'h20, 8'h05);
    repeat (2) @(posedge clk_i);
    check({30'h0, vector_o, inline_o}, 32'h1);
    wb(1'b1, 6'h1C, 8'h00);
    wb(1'b1, 6'h20, 8'h02);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    thresh_hit_i <= 1'b1;
    @(posedge clk_i);
    thresh_hit_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'h0, wake_o}, 32'h1);
    rdchk(6'h1C, 8'h02);
    sleep_i <= 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
